// ### sim/eccr_sva.sv
// Checker on the bus and decode ports of the current source register bank.
`timescale 1ns/1ps
module eccr_sva (
    input wire logic        I_CLK,
    input wire logic        I_RSTN,
    input wire logic        I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0]  I_HTRANS,
    input wire logic        I_HWRITE,
    input wire logic [31:0] I_HWDATA,
    input wire logic [31:0] O_HRDATA,
    input wire logic        O_HREADYOUT,
    input wire logic        O_HRESP,
    input wire logic        O_SRC2_PIN_COMMON,
    input wire logic [11:0] O_SRC1_LEVEL_UA,
    input wire logic [11:0] O_SRC2_LEVEL_UA,
    input wire logic        O_CODE_RESERVED
);
    localparam logic [31:0] MA = eccr_pkg::MAG_ADDR;
    localparam logic [31:0] PA = eccr_pkg::PIN_SEL_ADDR;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    sequence s_take(logic w, logic [31:0] a);
        I_HSEL && O_HREADYOUT && I_HTRANS[1] && I_HWRITE == w && I_HADDR == a;
    endsequence
    // A field code lands with the data phase; its decode shows two edges later.
    sequence s_wr(logic [31:0] a, int l, logic [3:0] c);
        s_take(1'b1, a) ##1 I_HWDATA[l+:4] == c;
    endsequence
    property p_bus; O_HREADYOUT && !O_HRESP; endproperty
    a_bus: assert property (p_bus) else $error("bus answer");
    property p_rdhi; s_take(1'b0, MA) |=> O_HRDATA[31:8] == 24'h000000; endproperty
    a_rdhi: assert property (p_rdhi) else $error("read upper bits");
    property p_rst; $rose(I_RSTN) |-> O_SRC2_LEVEL_UA == 12'h000 && !O_SRC2_PIN_COMMON; endproperty
    a_rst: assert property (p_rst) else $error("reset outputs");
    property p_m2; s_wr(MA, 4, 4'h1) |-> ##2 O_SRC2_LEVEL_UA == 12'h032; endproperty
    a_m2: assert property (p_m2) else $error("level two low");
    property p_mtop; s_wr(MA, 4, 4'ha) |-> ##2 O_SRC2_LEVEL_UA == 12'hbb8; endproperty
    a_mtop: assert property (p_mtop) else $error("level two top");
    property p_m1; s_wr(MA, 0, 4'h1) |-> ##2 O_SRC1_LEVEL_UA == 12'h032; endproperty
    a_m1: assert property (p_m1) else $error("level one");
    property p_com; s_wr(PA, 4, 4'ha) |-> ##2 O_SRC2_PIN_COMMON; endproperty
    a_com: assert property (p_com) else $error("common pin");
    property p_rsv; s_wr(MA, 0, 4'hc) |-> ##2 O_CODE_RESERVED; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved flag");
endmodule
bind eccr_top eccr_sva u_sva (.*);

// ### sim/tb.sv
// Bench driving the register bank over its bus and checking its outputs.
`timescale 1ns/1ps
module tb;
    logic        I_CLK, I_RSTN, I_HSEL, I_HWRITE, I_HREADY, O_HREADYOUT, O_HRESP;
    logic        O_SRC1_PIN_COMMON, O_SRC2_PIN_COMMON, O_CODE_RESERVED;
    logic [1:0]  I_HTRANS;
    logic [2:0]  I_HSIZE;
    logic [9:0]  O_SRC1_PIN_ONEHOT, O_SRC2_PIN_ONEHOT;
    logic [11:0] O_SRC1_LEVEL_UA, O_SRC2_LEVEL_UA;
    logic [31:0] I_HADDR, I_HWDATA, O_HRDATA, rd;
    int          n_errors = 0, comparisons = 0;
    // Reserved level codes drive no current.
    logic [11:0] ua [16] = '{12'h000, 12'h032, 12'h064, 12'h0fa, 12'h1f4, 12'h2ee, 12'h3e8,
        12'h5dc, 12'h7d0, 12'h9c4, 12'hbb8, 12'h000, 12'h000, 12'h000, 12'h000, 12'h000};
    eccr_top dut (.*);
    assign I_HREADY = O_HREADYOUT;
    initial begin
        I_CLK = 1'b0;
        forever #5 I_CLK = ~I_CLK;
    end
    task automatic tally_and_finish(input int tmo);
        n_errors += tmo;
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wait_rdy;
        int k = 0;
        do begin
            @(posedge I_CLK);
            if (++k > 20) tally_and_finish(1);
        end while (O_HREADYOUT !== 1'b1);
    endtask
    // Each phase is held until hready is seen, so a slower answer is still met.
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        {I_HSEL, I_HTRANS, I_HWRITE, I_HADDR} <= {1'b1, eccr_pkg::HTRANS_NONSEQ, w, a};
        wait_rdy();
        {I_HTRANS, I_HWDATA} <= {2'h0, d};
        wait_rdy();
        rd = O_HRDATA;
        chk("hresp", 32'h0, {31'h0, O_HRESP});
    endtask
    task automatic wrrd(input logic [31:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
        xfer(1'b0, a, 32'h0);
        chk("readback", {24'h0, d}, rd);
    endtask
    task automatic t_reset;
        xfer(1'b0, eccr_pkg::PIN_SEL_ADDR, 32'h0);
        chk("pin_rst", 32'h0000_00bb, rd);
        xfer(1'b0, eccr_pkg::MAG_ADDR, 32'h0);
        chk("mag_rst", 32'h0, rd);
        wrrd(32'h0000_003c, 8'h00);
    endtask
    task automatic t_codes;
        logic [3:0] c;
        logic [3:0] n;
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            n = ~c;
            wrrd(eccr_pkg::PIN_SEL_ADDR, {c, ~c});
            wrrd(eccr_pkg::MAG_ADDR, {c, c});
            chk("pin2", {21'h0, c == 4'ha, (c < 4'ha) ? 10'h1 << c : 10'h0},
                {21'h0, O_SRC2_PIN_COMMON, O_SRC2_PIN_ONEHOT});
            chk("pin1", {21'h0, n == 4'ha, (n < 4'ha) ? 10'h1 << n : 10'h0},
                {21'h0, O_SRC1_PIN_COMMON, O_SRC1_PIN_ONEHOT});
            chk("ua2", {20'h0, ua[i]}, {20'h0, O_SRC2_LEVEL_UA});
            chk("ua1", {20'h0, ua[i]}, {20'h0, O_SRC1_LEVEL_UA});
            chk("rsvd", {31'h0, c > 4'ha || c < 4'h4}, {31'h0, O_CODE_RESERVED});
        end
    endtask
    initial begin
        {I_RSTN, I_HSEL, I_HWRITE, I_HTRANS, I_HADDR, I_HWDATA} <= '0;
        I_HSIZE <= eccr_pkg::HSIZE_WORD;
        repeat (12) @(posedge I_CLK);
        I_RSTN <= 1'b1;
        t_reset();
        t_codes();
        tally_and_finish(0);
    end
endmodule

// ### src/eccr_pkg.sv
// Package with register map, field layout and decode constants for the excitation current regs.
package eccr_pkg;

    // Printed offsets 0Dh and 0Eh are not multiples of four: they are word indices.
    localparam logic [7:0]  PIN_SEL_IDX      = 8'h0d;
    localparam logic [7:0]  MAG_IDX          = 8'h0e;
    localparam logic [31:0] PIN_SEL_ADDR     = 32'h0000_0034;
    localparam logic [31:0] MAG_ADDR         = 32'h0000_0038;

    localparam logic [7:0]  PIN_SEL_RESET    = 8'hbb;
    localparam logic [7:0]  MAG_RESET        = 8'h00;

    localparam int          SRC2_LSB         = 4;
    localparam int          SRC1_LSB         = 0;
    localparam int          FIELD_W          = 4;

    // Pin-select codes.
    localparam logic [3:0]  PIN_LAST_AIN     = 4'h9;
    localparam logic [3:0]  PIN_COMMON       = 4'ha;
    localparam logic [3:0]  PIN_NONE         = 4'hb;

    // Magnitude codes.
    localparam logic [3:0]  MAG_OFF          = 4'h0;
    localparam logic [3:0]  MAG_LAST         = 4'ha;
    localparam int          MAG_UA_W         = 12;

    // AHB transfer types and size.
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ       = 2'h3;
    localparam logic [2:0]  HSIZE_WORD       = 3'h2;

    typedef enum logic [0:0] {
        ECCR_IDLE = 1'b0,
        ECCR_DATA = 1'b1
    } eccr_phase_t;

endpackage

// ### src/eccr_src_decode.sv
// One current source's decode from its pin and level fields into analog controls.
`timescale 1ns/1ps
module eccr_src_decode (
    input  wire logic [3:0]  i_pin,
    input  wire logic [3:0]  i_level,
    output logic             o_pin_valid,
    output logic             o_pin_common,
    output logic [9:0]       o_pin_onehot,
    output logic             o_level_valid,
    output logic [11:0]      o_level_ua
);

    always_comb begin
        o_pin_onehot = 10'h000;
        o_pin_common = (i_pin == eccr_pkg::PIN_COMMON);
        o_pin_valid  = (i_pin <= eccr_pkg::PIN_NONE);
        if (i_pin <= eccr_pkg::PIN_LAST_AIN) begin
            o_pin_onehot[i_pin] = 1'b1;
        end
    end

    // Reserved codes drive no current and flag themselves invalid.
    always_comb begin
        o_level_valid = (i_level <= eccr_pkg::MAG_LAST);
        unique case (i_level)
            4'h1:    o_level_ua = 12'h032;
            4'h2:    o_level_ua = 12'h064;
            4'h3:    o_level_ua = 12'h0fa;
            4'h4:    o_level_ua = 12'h1f4;
            4'h5:    o_level_ua = 12'h2ee;
            4'h6:    o_level_ua = 12'h3e8;
            4'h7:    o_level_ua = 12'h5dc;
            4'h8:    o_level_ua = 12'h7d0;
            4'h9:    o_level_ua = 12'h9c4;
            4'ha:    o_level_ua = 12'hbb8;
            default: o_level_ua = 12'h000;
        endcase
    end

endmodule

// ### src/eccr_top.sv
// AHB-Lite register bank that steers the two sensor-excitation current sources.
//
// What this block does
// - Pin-select register at index 0Dh, resets BBh.
// - Bits 7:4 route source two.
// - Bits 3:0 route source one, reset 1011.
// - Magnitude register at index 0Eh, resets 00h.
// - Bits 7:4 set source two current.
// - Bits 3:0 hold source one magnitude.
// - All fields read back last written value.
// - Source one magnitude decodes like source two.
`timescale 1ns/1ps
module eccr_top (
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic      [31:0] O_HRDATA,
    output logic             O_HREADYOUT,
    output logic             O_HRESP,
    output logic      [9:0]  O_SRC1_PIN_ONEHOT,
    output logic             O_SRC1_PIN_COMMON,
    output logic      [11:0] O_SRC1_LEVEL_UA,
    output logic      [9:0]  O_SRC2_PIN_ONEHOT,
    output logic             O_SRC2_PIN_COMMON,
    output logic      [11:0] O_SRC2_LEVEL_UA,
    output logic             O_CODE_RESERVED
);

    logic [7:0]  pin_sel_r;
    logic [7:0]  pin_sel_nxt;
    logic [7:0]  mag_r;
    logic [7:0]  mag_nxt;
    logic        wr_pin_r;
    logic        wr_pin_nxt;
    logic        wr_mag_r;
    logic        wr_mag_nxt;
    logic [31:0] hrdata_r;
    logic [31:0] hrdata_nxt;
    eccr_pkg::eccr_phase_t phase_r;
    eccr_pkg::eccr_phase_t phase_nxt;

    logic [9:0]  s1_onehot;
    logic [9:0]  s2_onehot;
    logic        s1_common;
    logic        s2_common;
    logic        s1_pin_ok;
    logic        s2_pin_ok;
    logic        s1_lvl_ok;
    logic        s2_lvl_ok;
    logic [11:0] s1_ua;
    logic [11:0] s2_ua;

    logic [9:0]  s1_onehot_r;
    logic [9:0]  s2_onehot_r;
    logic        s1_common_r;
    logic        s2_common_r;
    logic [11:0] s1_ua_r;
    logic [11:0] s2_ua_r;
    logic        reserved_r;

    logic        access;
    logic        hit_pin;
    logic        hit_mag;
    logic        hit_any;
    logic        wr_take;
    logic        rd_take;
    logic        pin_wr_en;
    logic        mag_wr_en;
    logic [7:0]  pin_rd_val;
    logic [7:0]  mag_rd_val;

    logic        hreadyout_r;
    logic        hreadyout_nxt;
    logic        hresp_r;
    logic        hresp_nxt;

    logic [3:0]  s1_pin_fld;
    logic [3:0]  s2_pin_fld;
    logic [3:0]  s1_lvl_fld;
    logic [3:0]  s2_lvl_fld;

    logic [9:0]  s1_onehot_nxt;
    logic [9:0]  s2_onehot_nxt;
    logic        s1_common_nxt;
    logic        s2_common_nxt;
    logic [11:0] s1_ua_nxt;
    logic [11:0] s2_ua_nxt;
    logic        s1_pin_rsv;
    logic        s2_pin_rsv;
    logic        s1_lvl_rsv;
    logic        s2_lvl_rsv;
    logic        reserved_nxt;

    // Zero-wait slave: every transfer completes in its first data-phase cycle.
    assign access    = I_HSEL && I_HREADY && I_HTRANS[1];
    assign hit_pin   = (I_HADDR == eccr_pkg::PIN_SEL_ADDR);
    assign hit_mag   = (I_HADDR == eccr_pkg::MAG_ADDR);
    assign hit_any   = hit_pin || hit_mag;
    assign wr_take   = access && I_HWRITE;
    assign rd_take   = access && !I_HWRITE;

    // Address phase: note which register the coming data phase writes.
    always_comb begin
        wr_pin_nxt = 1'b0;
        wr_mag_nxt = 1'b0;
        phase_nxt  = eccr_pkg::ECCR_IDLE;
        if (access) begin
            phase_nxt  = eccr_pkg::ECCR_DATA;
            wr_pin_nxt = wr_take && hit_pin;
            wr_mag_nxt = wr_take && hit_mag;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            wr_pin_r <= 1'b0;
            wr_mag_r <= 1'b0;
            phase_r  <= eccr_pkg::ECCR_IDLE;
        end else begin
            wr_pin_r <= wr_pin_nxt;
            wr_mag_r <= wr_mag_nxt;
            phase_r  <= phase_nxt;
        end
    end

    // Write strobes count only inside a data phase, never on a stale flag.
    assign pin_wr_en = (phase_r == eccr_pkg::ECCR_DATA) && wr_pin_r;
    assign mag_wr_en = (phase_r == eccr_pkg::ECCR_DATA) && wr_mag_r;

    // Reserved codes are stored as written; no filtering here.
    always_comb begin
        pin_sel_nxt = pin_sel_r;
        if (pin_wr_en) begin
            pin_sel_nxt = I_HWDATA[7:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            pin_sel_r <= eccr_pkg::PIN_SEL_RESET;
        end else begin
            pin_sel_r <= pin_sel_nxt;
        end
    end

    // Both sources stay off until software writes a level.
    always_comb begin
        mag_nxt = mag_r;
        if (mag_wr_en) begin
            mag_nxt = I_HWDATA[7:0];
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            mag_r <= eccr_pkg::MAG_RESET;
        end else begin
            mag_r <= mag_nxt;
        end
    end

    // Reads bypass a same-cycle write, so a read right after a write is fresh.
    assign pin_rd_val = pin_sel_nxt;
    assign mag_rd_val = mag_nxt;

    // Unmapped addresses read zero; bits above the byte are zero.
    always_comb begin
        hrdata_nxt = hrdata_r;
        if (rd_take) begin
            if (!hit_any) begin
                hrdata_nxt = 32'h0000_0000;
            end else if (hit_pin) begin
                hrdata_nxt = {24'h000000, pin_rd_val};
            end else begin
                hrdata_nxt = {24'h000000, mag_rd_val};
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            hrdata_r <= 32'h0000_0000;
        end else begin
            hrdata_r <= hrdata_nxt;
        end
    end

    // The slave never stalls or errors, but both answers still leave from flops.
    always_comb begin
        hreadyout_nxt = 1'b1;
        hresp_nxt     = 1'b0;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            hreadyout_r <= 1'b1;
            hresp_r     <= 1'b0;
        end else begin
            hreadyout_r <= hreadyout_nxt;
            hresp_r     <= hresp_nxt;
        end
    end

    // Source two sits in the upper nibble of each register.
    assign s1_pin_fld = pin_sel_r[eccr_pkg::SRC1_LSB +: eccr_pkg::FIELD_W];
    assign s2_pin_fld = pin_sel_r[eccr_pkg::SRC2_LSB +: eccr_pkg::FIELD_W];
    assign s1_lvl_fld = mag_r[eccr_pkg::SRC1_LSB +: eccr_pkg::FIELD_W];
    assign s2_lvl_fld = mag_r[eccr_pkg::SRC2_LSB +: eccr_pkg::FIELD_W];

    eccr_src_decode u_src1 (
        .i_pin         (s1_pin_fld),
        .i_level       (s1_lvl_fld),
        .o_pin_valid   (s1_pin_ok),
        .o_pin_common  (s1_common),
        .o_pin_onehot  (s1_onehot),
        .o_level_valid (s1_lvl_ok),
        .o_level_ua    (s1_ua)
    );

    eccr_src_decode u_src2 (
        .i_pin         (s2_pin_fld),
        .i_level       (s2_lvl_fld),
        .o_pin_valid   (s2_pin_ok),
        .o_pin_common  (s2_common),
        .o_pin_onehot  (s2_onehot),
        .o_level_valid (s2_lvl_ok),
        .o_level_ua    (s2_ua)
    );

    // Analog controls are registered so glitches never reach the sources.
    always_comb begin
        s1_onehot_nxt = s1_onehot;
        s1_common_nxt = s1_common;
        s1_ua_nxt     = s1_ua;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s1_onehot_r <= 10'h000;
            s1_common_r <= 1'b0;
            s1_ua_r     <= 12'h000;
        end else begin
            s1_onehot_r <= s1_onehot_nxt;
            s1_common_r <= s1_common_nxt;
            s1_ua_r     <= s1_ua_nxt;
        end
    end

    // Source two has its own group so each source can be retimed alone.
    always_comb begin
        s2_onehot_nxt = s2_onehot;
        s2_common_nxt = s2_common;
        s2_ua_nxt     = s2_ua;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            s2_onehot_r <= 10'h000;
            s2_common_r <= 1'b0;
            s2_ua_r     <= 12'h000;
        end else begin
            s2_onehot_r <= s2_onehot_nxt;
            s2_common_r <= s2_common_nxt;
            s2_ua_r     <= s2_ua_nxt;
        end
    end

    // The flag only reports; reserved codes already drive no current or pin.
    always_comb begin
        s1_pin_rsv   = !s1_pin_ok;
        s2_pin_rsv   = !s2_pin_ok;
        s1_lvl_rsv   = !s1_lvl_ok;
        s2_lvl_rsv   = !s2_lvl_ok;
        reserved_nxt = s1_pin_rsv || s2_pin_rsv || s1_lvl_rsv || s2_lvl_rsv;
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            reserved_r <= 1'b0;
        end else begin
            reserved_r <= reserved_nxt;
        end
    end

    assign O_HRDATA          = hrdata_r;
    assign O_HREADYOUT       = hreadyout_r;
    assign O_HRESP           = hresp_r;
    assign O_SRC1_PIN_ONEHOT = s1_onehot_r;
    assign O_SRC1_PIN_COMMON = s1_common_r;
    assign O_SRC1_LEVEL_UA   = s1_ua_r;
    assign O_SRC2_PIN_ONEHOT = s2_onehot_r;
    assign O_SRC2_PIN_COMMON = s2_common_r;
    assign O_SRC2_LEVEL_UA   = s2_ua_r;
    assign O_CODE_RESERVED   = reserved_r;

endmodule
